// >>> design/dpc_consts.svh
`ifndef DPC_CONSTS_SVH
`define DPC_CONSTS_SVH
// Register indices (printed offsets are indices, address is four times)
`define DPC_IDX_TARGET     8'h03
`define DPC_IDX_ADDR_HI    8'h04
`define DPC_IDX_ADDR_LO    8'h05
`define DPC_IDX_DATA       8'h06
`define DPC_IDX_CMD        8'h07
`define DPC_IDX_FEED_LO    8'h48
`define DPC_IDX_FEED_HI    8'h49
`define DPC_IDX_MODE_SEL   8'h26
`define DPC_IDX_STATUS     8'h3F
// Field positions
`define DPC_TGT_SEL_BIT    0
`define DPC_TGT_COL_LSB    1
`define DPC_DIR_BIT        5
`define DPC_MODEA_COL_LSB  3
`define DPC_MODEA_EN_BIT   0
`define DPC_CMD_STBY_BIT   2
`define DPC_CMD_RST_BIT    3
// Address limits
`define DPC_LIM_GAMMA      12'd1023
`define DPC_LIM_COEF300    13'd2729
`define DPC_LIM_COEF600    13'd5459
// Reset values
`define DPC_RST_BYTE       8'h00
`define DPC_RST_FEED       16'h0100
`endif

// >>> design/dpc_pkg.sv
package dpc_pkg;
   typedef enum logic [1:0] {
      DPC_IDLE, DPC_FWD, DPC_REV, DPC_SCAN
   } dpc_cmd_t;
endpackage : dpc_pkg

// >>> design/dpc_regs.sv
`timescale 1ns/1ps
`include "dpc_consts.svh"
module dpc_regs
   import dpc_pkg::*;
#(
   parameter int LINE_LEN = 16   // Clocks per scan line
) (
   input  wire logic        ref_clk,      // 125 MHz clock
   input  wire logic        reset_n,      // Async reset, active low
   input  wire logic        psel,         // APB select
   input  wire logic        penable,      // APB enable
   input  wire logic        pwrite,       // APB direction
   input  wire logic [9:0]  paddr,        // APB byte address
   input  wire logic [31:0] pwdata,       // APB write data
   output logic      [31:0] prdata,       // APB read data
   output logic             pready,       // APB ready
   output logic             pslverr,      // APB error on unmapped address
   input  wire logic [7:0]  port_rd_data, // Byte returned by storage
   output logic             port_wr_stb,  // Storage write strobe
   output logic             port_rd_stb,  // Storage read strobe
   output logic             port_coef,    // Target is coefficient storage
   output logic      [1:0]  port_color,   // Gamma table colour in use
   output logic      [11:0] port_addr,    // Current port address
   output logic             port_hi_byte, // Second byte of coefficient pair
   output logic      [7:0]  port_wr_data, // Byte written to storage
   output logic      [3:0]  motor_phase,  // Motor phase outputs
   output logic             motor_step,   // One-cycle step pulse
   output logic             motor_dir_rev,// Stepping backward
   output logic             scan_active,  // Image acquisition running
   output logic             ptr_clear,    // Data pointer reset pulse
   output logic             sensor_clk,   // Sensor clock
   output logic             clk_freeze,   // Internal clocks frozen
   output logic             analog_pd,    // Analog power down
   output logic             core_reset    // Soft reset held
);

   typedef struct packed {
      logic [7:0]  target;
      logic [7:0]  addr_hi;
      logic [7:0]  addr_lo;
      logic [7:0]  cmd;
      logic [7:0]  mode_sel;
      logic [15:0] feed;
      logic        pair_hi;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic        wr_stb;
      logic        rd_stb;
      logic [7:0]  wr_data;
      logic [15:0] step_cnt;
      logic [1:0]  phase_idx;
      logic        step;
      logic        scan;
      logic        scan_pend;
      logic        clr;
      logic [15:0] line_cnt;
      logic        sclk;
      logic [1:0]  color_o;
      logic [3:0]  phase_o;
      logic        dir_o;
   } dpc_state_t;

   dpc_state_t s_r;
   dpc_state_t s_nxt;

   logic [7:0] idx;
   logic       acc;
   dpc_cmd_t   cmd_f;
   logic       hold;
   logic       coef;

   assign idx   = paddr[9:2];
   assign acc   = psel && penable && !s_r.pready;
   assign cmd_f = dpc_cmd_t'(s_r.cmd[1:0]);
   assign hold  = s_r.cmd[`DPC_CMD_RST_BIT] || s_r.cmd[`DPC_CMD_STBY_BIT];
   assign coef  = s_r.target[`DPC_TGT_SEL_BIT];

   // Register bus, port stream and motor/scan control
   always_comb begin
      logic [11:0] a;
      logic        adv;
      dpc_cmd_t    nc;
      a     = {s_r.addr_hi[3:0], s_r.addr_lo};
      nc    = cmd_f;
      adv   = 1'b0;
      s_nxt = s_r;
      s_nxt.pready  = acc;
      s_nxt.pslverr = 1'b0;
      s_nxt.wr_stb  = 1'b0;
      s_nxt.rd_stb  = 1'b0;
      s_nxt.step    = 1'b0;
      s_nxt.clr     = 1'b0;
      if (acc) begin
         s_nxt.prdata = 32'h0000_0000;
         if (idx == `DPC_IDX_TARGET) begin
            if (pwrite) s_nxt.target = pwdata[7:0];
            s_nxt.prdata[7:0] = s_r.target;
         end else if (idx == `DPC_IDX_ADDR_HI) begin
            if (pwrite) begin
               s_nxt.addr_hi = pwdata[7:0];
               s_nxt.pair_hi = 1'b0;
            end
            s_nxt.prdata[7:0] = s_r.addr_hi;
         end else if (idx == `DPC_IDX_ADDR_LO) begin
            if (pwrite) begin
               s_nxt.addr_lo = pwdata[7:0];
               s_nxt.pair_hi = 1'b0;
            end
            s_nxt.prdata[7:0] = s_r.addr_lo;
         end else if (idx == `DPC_IDX_DATA) begin
            // Direction comes from the address register, not the bus
            if (s_r.addr_hi[`DPC_DIR_BIT]) begin
               s_nxt.rd_stb      = 1'b1;
               s_nxt.prdata[7:0] = port_rd_data;
            end else begin
               s_nxt.wr_stb  = pwrite;
               s_nxt.wr_data = pwdata[7:0];
            end
            // Coefficients occupy two bytes per address
            if (coef) begin
               s_nxt.pair_hi = !s_r.pair_hi;
               adv = s_r.pair_hi;
            end else begin
               adv = 1'b1;
            end
         end else if (idx == `DPC_IDX_CMD) begin
            if (pwrite) begin
               s_nxt.cmd = pwdata[7:0];
               if (pwdata[1:0] == 2'b11 && cmd_f != DPC_SCAN) begin
                  s_nxt.clr       = 1'b1;
                  s_nxt.scan_pend = 1'b1;
               end
            end
            s_nxt.prdata[7:0] = s_r.cmd;
         end else if (idx == `DPC_IDX_MODE_SEL) begin
            if (pwrite) s_nxt.mode_sel = pwdata[7:0];
            s_nxt.prdata[7:0] = s_r.mode_sel;
         end else if (idx == `DPC_IDX_FEED_LO) begin
            if (pwrite) s_nxt.feed[7:0] = pwdata[7:0];
            s_nxt.prdata[7:0] = s_r.feed[7:0];
         end else if (idx == `DPC_IDX_FEED_HI) begin
            if (pwrite) s_nxt.feed[15:8] = pwdata[7:0];
            s_nxt.prdata[7:0] = s_r.feed[15:8];
         end else if (idx == `DPC_IDX_STATUS) begin
            s_nxt.prdata[4:0] = {s_r.scan, s_r.pair_hi, hold, cmd_f};
         end else begin
            s_nxt.pslverr = 1'b1;
         end
      end
      if (adv) begin
         a = a + 12'd1;
         s_nxt.addr_hi[3:0] = a[11:8];
         s_nxt.addr_lo      = a[7:0];
      end
      if (s_r.cmd[`DPC_CMD_RST_BIT]) begin
         // Soft reset clears the engine but keeps host registers writable
         s_nxt.scan      = 1'b0;
         s_nxt.scan_pend = 1'b0;
         s_nxt.step_cnt  = 16'h0000;
         s_nxt.line_cnt  = 16'h0000;
         s_nxt.phase_idx = 2'b00;
      end else if (!s_r.cmd[`DPC_CMD_STBY_BIT]) begin
         // Sensor clock runs in every command, idle included, unless standby or soft reset is set
         s_nxt.sclk = !s_r.sclk;
         if (s_r.scan_pend && !s_r.clr) begin
            s_nxt.scan_pend = 1'b0;
            s_nxt.scan      = 1'b1;
            s_nxt.line_cnt  = 16'h0000;
         end else if (s_r.scan) begin
            if (s_r.line_cnt == 16'(LINE_LEN - 1)) begin
               s_nxt.line_cnt = 16'h0000;
               // Idle only takes effect at a line boundary
               if (cmd_f != DPC_SCAN) s_nxt.scan = 1'b0;
            end else begin
               s_nxt.line_cnt = s_r.line_cnt + 16'd1;
            end
         end
         if (cmd_f == DPC_FWD || cmd_f == DPC_REV) begin
            if (s_r.step_cnt >= s_r.feed) begin
               s_nxt.step_cnt = 16'h0000;
               s_nxt.step     = 1'b1;
               s_nxt.phase_idx = (cmd_f == DPC_FWD) ? s_r.phase_idx + 2'd1
                                                    : s_r.phase_idx - 2'd1;
            end else begin
               s_nxt.step_cnt = s_r.step_cnt + 16'd1;
            end
         end else begin
            s_nxt.step_cnt = 16'h0000;
         end
      end
      // Pin decodes use the next state, so the pins leave flops with no extra lag
      nc = dpc_cmd_t'(s_nxt.cmd[1:0]);
      // Mode A overrides target colour for gamma tables
      s_nxt.color_o = s_nxt.mode_sel[`DPC_MODEA_EN_BIT] ?
                      s_nxt.mode_sel[`DPC_MODEA_COL_LSB +: 2] :
                      s_nxt.target[`DPC_TGT_COL_LSB +: 2];
      // Phases low whenever the motor is not commanded to move
      if (nc == DPC_FWD || nc == DPC_REV) begin
         s_nxt.phase_o = 4'h1 << s_nxt.phase_idx;
      end else begin
         s_nxt.phase_o = 4'h0;
      end
      s_nxt.dir_o = (nc == DPC_REV);
   end

   // State register
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         s_r      <= '0;
         s_r.feed <= `DPC_RST_FEED;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from flip-flops
   assign prdata        = s_r.prdata;
   assign pready        = s_r.pready;
   assign pslverr       = s_r.pslverr;
   assign port_wr_stb   = s_r.wr_stb;
   assign port_rd_stb   = s_r.rd_stb;
   assign port_coef     = s_r.target[`DPC_TGT_SEL_BIT];
   assign port_color    = s_r.color_o;
   assign port_addr     = {s_r.addr_hi[3:0], s_r.addr_lo};
   assign port_hi_byte  = s_r.pair_hi;
   assign port_wr_data  = s_r.wr_data;
   assign motor_phase   = s_r.phase_o;
   assign motor_step    = s_r.step;
   assign motor_dir_rev = s_r.dir_o;
   assign scan_active   = s_r.scan;
   assign ptr_clear     = s_r.clr;
   assign sensor_clk    = s_r.sclk;
   assign clk_freeze    = s_r.cmd[`DPC_CMD_STBY_BIT];
   assign analog_pd     = s_r.cmd[`DPC_CMD_STBY_BIT];
   assign core_reset    = s_r.cmd[`DPC_CMD_RST_BIT];

   // Assertions
   property p_dir_read;
      @(posedge ref_clk) disable iff (!reset_n)
      (acc && idx == `DPC_IDX_DATA && s_r.addr_hi[`DPC_DIR_BIT]) |=> port_rd_stb && !port_wr_stb;
   endproperty
   a_dir_read: assert property (p_dir_read) else $error("read dir not honoured");

   property p_gamma_inc;
      @(posedge ref_clk) disable iff (!reset_n)
      (acc && idx == `DPC_IDX_DATA && !coef && !core_reset)
      |=> port_addr == $past(port_addr) + 12'd1;
   endproperty
   a_gamma_inc: assert property (p_gamma_inc) else $error("gamma address not advanced");

   property p_coef_pair;
      @(posedge ref_clk) disable iff (!reset_n)
      (acc && idx == `DPC_IDX_DATA && coef && !port_hi_byte)
      |=> port_addr == $past(port_addr) && port_hi_byte;
   endproperty
   a_coef_pair: assert property (p_coef_pair) else $error("coef first byte advanced");

   property p_color;
      @(posedge ref_clk) disable iff (!reset_n)
      s_r.mode_sel[`DPC_MODEA_EN_BIT] |-> port_color == s_r.mode_sel[4:3];
   endproperty
   a_color: assert property (p_color) else $error("mode A colour wrong");

   property p_idle_phase;
      @(posedge ref_clk) disable iff (!reset_n)
      // A step launched on the edge that writes idle may still show for one cycle
      cmd_f == DPC_IDLE |-> motor_phase == 4'h0 && (!motor_step || $past(cmd_f) != DPC_IDLE);
   endproperty
   a_idle_phase: assert property (p_idle_phase) else $error("phases active in idle");

   property p_sclk;
      @(posedge ref_clk) disable iff (!reset_n)
      // The first edge after reset release still holds the reset value
      (!hold && !$past(hold) && $past(reset_n)) |-> sensor_clk != $past(sensor_clk);
   endproperty
   a_sclk: assert property (p_sclk) else $error("sensor clock stopped");

   property p_fwd;
      @(posedge ref_clk) disable iff (!reset_n)
      (motor_step && !motor_dir_rev && $past(cmd_f) == DPC_FWD)
      |-> s_r.phase_idx == $past(s_r.phase_idx) + 2'd1;
   endproperty
   a_fwd: assert property (p_fwd) else $error("forward step wrong");

   property p_rev;
      @(posedge ref_clk) disable iff (!reset_n)
      (motor_step && $past(cmd_f) == DPC_REV)
      |-> s_r.phase_idx == $past(s_r.phase_idx) - 2'd1;
   endproperty
   a_rev: assert property (p_rev) else $error("reverse step wrong");

   sequence s_start;
      ptr_clear && !hold;
   endsequence
   property p_scan;
      @(posedge ref_clk) disable iff (!reset_n)
      s_start ##1 !hold |=> scan_active;
   endproperty
   a_scan: assert property (p_scan) else $error("scan not started");

   property p_stby;
      @(posedge ref_clk) disable iff (!reset_n)
      (clk_freeze && $past(clk_freeze)) |-> $stable(sensor_clk) && !motor_step;
   endproperty
   a_stby: assert property (p_stby) else $error("clocks not frozen");

   property p_rst;
      @(posedge ref_clk) disable iff (!reset_n)
      core_reset |=> !scan_active;
   endproperty
   a_rst: assert property (p_rst) else $error("scan runs in soft reset");

   // Second byte of a coefficient pair moves the address and restarts pairing
   sequence s_coef_second;
      acc && idx == `DPC_IDX_DATA && coef && port_hi_byte;
   endsequence
   property p_coef_adv;
      @(posedge ref_clk) disable iff (!reset_n)
      s_coef_second |=> port_addr == $past(port_addr) + 12'd1 && !port_hi_byte;
   endproperty
   a_coef_adv: assert property (p_coef_adv) else $error("coef pair not advanced");

   // Idle must not cut a line short; outside soft reset only the last clock of a line may end it
   sequence s_mid_line;
      scan_active && !hold && s_r.line_cnt != 16'(LINE_LEN - 1);
   endsequence
   property p_line_end;
      @(posedge ref_clk) disable iff (!reset_n)
      s_mid_line |=> scan_active;
   endproperty
   a_line_end: assert property (p_line_end) else $error("scan ended mid line");

endmodule : dpc_regs

// >>> verif/dpc_store_model.sv
`timescale 1ns/1ps
// Behavioural storage behind the data port: gamma tables and coefficient memory
module dpc_store_model (
   input  wire logic        ref_clk,      // Clock
   input  wire logic        port_wr_stb,  // Write strobe from the port
   input  wire logic [7:0]  port_wr_data, // Byte written
   input  wire logic [11:0] port_addr,    // Current port address
   output logic      [7:0]  port_rd_data, // Byte returned to the port
   output logic      [7:0]  last_byte,    // Last byte stored
   output int               wr_cnt        // Number of stores seen
);
   // Content is a fixed function of the address, so reads need no preload
   assign port_rd_data = port_addr[7:0] ^ 8'h5A;
   // Log every store; address is not logged since it may already have advanced
   always_ff @(posedge ref_clk) begin
      if (port_wr_stb) begin
         last_byte <= port_wr_data;
         wr_cnt    <= wr_cnt + 1;
      end
   end
endmodule : dpc_store_model

// >>> verif/dataport_and_command_regs_test.sv
`timescale 1ns/1ps
`include "dpc_consts.svh"
module dataport_and_command_regs_test;
   import dpc_pkg::*;
   localparam logic [9:0] A_TGT = {`DPC_IDX_TARGET, 2'b00};
   localparam logic [9:0] A_HI  = {`DPC_IDX_ADDR_HI, 2'b00};
   localparam logic [9:0] A_LO  = {`DPC_IDX_ADDR_LO, 2'b00};
   localparam logic [9:0] A_DAT = {`DPC_IDX_DATA, 2'b00};
   localparam logic [9:0] A_CMD = {`DPC_IDX_CMD, 2'b00};
   localparam logic [9:0] A_MOD = {`DPC_IDX_MODE_SEL, 2'b00};
   localparam logic [9:0] A_FLO = {`DPC_IDX_FEED_LO, 2'b00};
   localparam logic [9:0] A_FHI = {`DPC_IDX_FEED_HI, 2'b00};
   localparam logic [9:0] A_STS = {`DPC_IDX_STATUS, 2'b00};
   logic        ref_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic [9:0]  paddr = '0;
   logic [31:0] pwdata = '0, prdata;
   logic        pready, pslverr, wr_stb, rd_stb, coef, hi_byte, motor_step, dir_rev;
   logic        scan_active, ptr_clear, sensor_clk, clk_freeze, analog_pd, core_reset;
   logic [1:0]  color;
   logic [3:0]  motor_phase;
   logic [7:0]  rd_byte, wr_byte, last_byte;
   logic [11:0] port_addr;
   logic        clr_seen = 0, rd_seen = 0;
   int          wr_cnt, error_cnt = 0, n_tests = 0;

   dpc_regs #(.LINE_LEN(8)) i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .port_rd_data(rd_byte), .port_wr_stb(wr_stb),
      .port_rd_stb(rd_stb), .port_coef(coef), .port_color(color), .port_addr(port_addr),
      .port_hi_byte(hi_byte), .port_wr_data(wr_byte), .motor_phase(motor_phase),
      .motor_step(motor_step), .motor_dir_rev(dir_rev), .scan_active(scan_active),
      .ptr_clear(ptr_clear), .sensor_clk(sensor_clk), .clk_freeze(clk_freeze),
      .analog_pd(analog_pd), .core_reset(core_reset));
   dpc_store_model i_store (.ref_clk(ref_clk), .port_wr_stb(wr_stb), .port_wr_data(wr_byte),
      .port_addr(port_addr), .port_rd_data(rd_byte), .last_byte(last_byte), .wr_cnt(wr_cnt));

   // Clock, and sticky flags since the pointer clear and the read strobe are single-cycle pulses
   always #4 ref_clk = ~ref_clk;
   always @(negedge ref_clk) if (ptr_clear === 1'b1) clr_seen <= 1'b1;
   always @(negedge ref_clk) if (rd_stb === 1'b1) rd_seen <= 1'b1;

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : end_of_test

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // One APB transfer; entered and left just after a rising edge
   task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d,
                      output logic [31:0] rd, output logic err);
      int k;
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
      @(posedge ref_clk);
      penable <= 1'b1;
      // Ready, read data and error are taken at the rising edge that sees ready
      for (k = 0; k < 20; k++) begin
         @(posedge ref_clk);
         if (pready === 1'b1) break;
      end
      if (k == 20) begin
         error_cnt++;
         end_of_test();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask : apb

   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      logic [31:0] rd; logic e;
      apb(1'b1, a, d, rd, e);
      chk("write error flag", 0, e);
   endtask : wr

   task automatic t_regs;
      logic [31:0] rd; logic e;
      apb(1'b0, A_CMD, 0, rd, e); chk("cmd reset", 0, rd);
      apb(1'b0, A_FHI, 0, rd, e); chk("feed hi reset", 32'h0000_0001, rd);
      apb(1'b1, 10'h3F0, 8'h55, rd, e); chk("unmapped error", 1, e);
      wr(A_LO, 8'hC3); apb(1'b0, A_LO, 0, rd, e); chk("addr lo readback", 32'h0000_00C3, rd);
   endtask : t_regs

   // Gamma target: colour codes, address forming, one byte per step, back to back
   task automatic t_gamma;
      int w0;
      for (int c = 0; c < 3; c++) begin
         wr(A_TGT, 8'(c << 1)); chk("colour", c, color);
      end
      wr(A_TGT, 8'h02); chk("target coef", 0, coef);
      wr(A_HI, 8'h03); wr(A_LO, 8'hFE); chk("port addr", 12'h3FE, port_addr);
      w0 = wr_cnt;
      wr(A_DAT, 8'hA5); wr(A_DAT, 8'h3C);
      chk("gamma advance", 12'h400, port_addr);
      chk("stores", 2, wr_cnt - w0);
      chk("stored byte", 8'h3C, last_byte);
   endtask : t_gamma

   // Coefficient target: address holds until the second byte of the pair
   task automatic t_coef;
      wr(A_TGT, 8'h01); chk("target coef", 1, coef);
      wr(A_HI, 8'h00); wr(A_LO, 8'h10);
      wr(A_DAT, 8'h11); chk("coef hold", 12'h010, port_addr);
      chk("pair high next", 1, hi_byte);
      wr(A_DAT, 8'h22); chk("coef advance", 12'h011, port_addr);
   endtask : t_coef

   // Read direction from bit 5 of the upper address register
   task automatic t_read;
      logic [31:0] rd; logic e; int w0;
      wr(A_TGT, 8'h00); wr(A_HI, 8'h21); wr(A_LO, 8'h23);
      w0 = wr_cnt;
      apb(1'b0, A_DAT, 0, rd, e); chk("read byte", 8'h79, rd[7:0]);
      chk("read strobe", 1, rd_seen);
      chk("read advance", 12'h124, port_addr);
      chk("no store on read", 0, wr_cnt - w0);
   endtask : t_read

   task automatic t_modea;
      wr(A_TGT, 8'h02); wr(A_MOD, 8'h11); chk("mode A colour", 2, color);
      wr(A_MOD, 8'h00); chk("normal colour", 1, color);
   endtask : t_modea

   // Cycles between two step pulses
   task automatic step_gap(output int n);
      int k;
      for (k = 0; k < 50; k++) begin
         @(negedge ref_clk);
         if (motor_step === 1'b1) break;
      end
      n = 0;
      do begin
         @(negedge ref_clk);
         n++;
      end while (motor_step !== 1'b1 && n < 50);
      if (k == 50 || n == 50) begin
         error_cnt++;
         end_of_test();
      end
      @(posedge ref_clk);
   endtask : step_gap

   task automatic t_motor;
      int n; logic s0;
      wr(A_FLO, 8'h03); wr(A_FHI, 8'h00);
      wr(A_CMD, 8'h01); step_gap(n); chk("fwd step gap", 4, n);
      chk("fwd direction", 0, dir_rev);
      chk("phase on", 1, motor_phase != 4'h0);
      wr(A_CMD, 8'h02); step_gap(n); chk("rev step gap", 4, n);
      chk("rev direction", 1, dir_rev);
      wr(A_CMD, 8'h00); @(negedge ref_clk); chk("idle phases", 4'h0, motor_phase);
      s0 = sensor_clk;
      @(negedge ref_clk); chk("sensor clk toggles", !s0, sensor_clk);
      @(posedge ref_clk);
   endtask : t_motor

   task automatic t_scan;
      int k;
      wr(A_CMD, 8'h03); repeat (3) @(negedge ref_clk);
      chk("pointer clear", 1, clr_seen);
      chk("scan running", 1, scan_active);
      @(posedge ref_clk);
      wr(A_CMD, 8'h00);
      for (k = 0; k < 20 && scan_active === 1'b1; k++) @(negedge ref_clk);
      if (k == 20) begin
         error_cnt++;
         end_of_test();
      end
      chk("scan ends at line end", 0, scan_active);
      @(posedge ref_clk);
   endtask : t_scan

   task automatic t_power;
      logic [31:0] rd; logic e;
      wr(A_CMD, 8'h04); chk("freeze", 1, clk_freeze);
      apb(1'b0, A_STS, 0, rd, e); chk("status hold", 32'h0000_0004, rd);
      chk("analog down", 1, analog_pd);
      wr(A_CMD, 8'h00); chk("resume", 0, clk_freeze | analog_pd);
      wr(A_CMD, 8'h08); chk("soft reset held", 1, core_reset);
      wr(A_CMD, 8'h00); chk("soft reset left", 0, core_reset);
   endtask : t_power

   // Main sequence
   initial begin
      repeat (6) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(posedge ref_clk);
      t_regs();
      t_gamma();
      t_coef();
      t_read();
      t_modea();
      t_motor();
      t_scan();
      t_power();
      end_of_test();
   end
endmodule : dataport_and_command_regs_test
